// >>> verilog/ilxu_top.sv
// Integer and logic execution datapath with one-cycle result registers.
//
// Decided for this implementation: the plain strobed port and the register offsets.
module ilxu_top (
  input  wire logic                ref_clk_i,  // Core clock, 200 MHz.
  input  wire logic                rst_n_i,    // Synchronous reset, active low.
  input  wire logic                clk_en_i,   // Clock enable; all state holds while low.
  input  wire logic                valid_i,    // Request is presented this cycle.
  input  wire ilxu_pkg::ilxu_req_s req_i,      // Request fields.
  output logic                     valid_o,    // Answer stands this cycle.
  output ilxu_pkg::ilxu_rsp_s      rsp_o,      // Answer fields.
  output logic                     irq_o,      // Level interrupt, unmasked event pending.
  input  wire logic                reg_wr_i,   // Register write strobe.
  input  wire logic                reg_rd_i,   // Register read strobe.
  input  wire logic [1:0]          reg_addr_i, // Register word index.
  input  wire logic [31:0]         reg_wdata_i,// Register write data.
  output logic [31:0]              reg_rdata_o // Register read data, one cycle after read.
);

  // ----------------------------------------------------------------------
  // Local register map
  // ----------------------------------------------------------------------
  localparam logic [1:0] ADDR_STATUS = 2'h0; // Sticky event bits, write one to clear.
  localparam logic [1:0] ADDR_MASK   = 2'h1; // Interrupt enable per event.
  localparam logic [1:0] ADDR_COUNT  = 2'h2; // Completed operation count.
  localparam int unsigned EV_W       = 3;    // Events: overflow, zero divide, type.

  // ----------------------------------------------------------------------
  // Local names for package constants
  // ----------------------------------------------------------------------
  // Result words and condition codes.
  localparam logic [31:0] ALL_ONES   = ilxu_pkg::ALL_ONES;
  localparam logic [31:0] RST_WORD   = ilxu_pkg::RST_WORD;
  localparam logic [2:0]  CC_FOUND   = ilxu_pkg::CC_FOUND;
  localparam logic [2:0]  CC_NONE    = ilxu_pkg::CC_NONE;

  // Multiply and remainder selects.
  localparam logic [11:0] OP_MUL_S   = ilxu_pkg::OP_MUL_S;
  localparam logic [11:0] OP_MUL_U   = ilxu_pkg::OP_MUL_U;
  localparam logic [11:0] OP_REM_S   = ilxu_pkg::OP_REM_S;
  localparam logic [11:0] OP_REM_U   = ilxu_pkg::OP_REM_U;

  // Bitwise family selects.
  localparam logic [11:0] OP_NAND    = ilxu_pkg::OP_NAND;
  localparam logic [11:0] OP_NOR     = ilxu_pkg::OP_NOR;
  localparam logic [11:0] OP_NOT     = ilxu_pkg::OP_NOT;
  localparam logic [11:0] OP_NOTAND  = ilxu_pkg::OP_NOTAND;
  localparam logic [11:0] OP_NOTOR   = ilxu_pkg::OP_NOTOR;
  localparam logic [11:0] OP_OR      = ilxu_pkg::OP_OR;
  localparam logic [11:0] OP_ORNOT   = ilxu_pkg::OP_ORNOT;

  // Bit, rotate, scan and match selects.
  localparam logic [11:0] OP_TOGGLE  = ilxu_pkg::OP_TOGGLE;
  localparam logic [11:0] OP_ROTATE  = ilxu_pkg::OP_ROTATE;
  localparam logic [11:0] OP_SCAN    = ilxu_pkg::OP_SCAN;
  localparam logic [11:0] OP_BYTEMAT = ilxu_pkg::OP_BYTEMAT;

  // ----------------------------------------------------------------------
  // Operand decode
  // ----------------------------------------------------------------------
  wire logic [31:0] s1 = req_i.src1; // First source.
  wire logic [31:0] s2 = req_i.src2; // Second source.
  wire logic [11:0] op = req_i.op;   // Operation select.

  // Signed and unsigned product; the low word is the same for both.
  wire logic signed [63:0] prod_s = $signed({{32{s1[31]}}, s1}) * $signed({{32{s2[31]}}, s2});
  wire logic [31:0] prod_lo = prod_s[31:0];
  // Signed overflow when the upper word is not the sign extension of the low word.
  wire logic mul_ovf = (prod_s[63:32] != {32{prod_s[31]}});

  // Divisor is zero for both remainder forms.
  wire logic div_zero = (s1 == RST_WORD);
  // Remainder of most negative over minus one overflows the quotient.
  wire logic rem_ovf = (s2 == 32'h80000000) && (s1 == ALL_ONES);
  // Safe divisor avoids divide by zero inside the operators.
  wire logic [31:0] div_safe = div_zero ? 32'h00000001 : s1;
  // Truncating remainder; sign follows the dividend (second source).
  wire logic [31:0] rem_s = rem_ovf ? RST_WORD : 32'($signed(s2) % $signed(div_safe));
  wire logic [31:0] rem_u = s2 % div_safe;

  // Toggle mask from bit position modulo 32.
  wire logic [31:0] tog_mask = 32'h00000001 << s1[4:0];
  // Rotate left by length modulo 32.
  wire logic [63:0] rot_dbl = {s2, s2} << s1[4:0];
  wire logic [31:0] rot_res = rot_dbl[63:32];

  // Per-lane byte equality flags.
  logic [3:0] lane_eq;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign lane_eq[g] = (s1[8*g +: 8] == s2[8*g +: 8]);
    end
  endgenerate

  // Highest set bit search, walking up from bit 0; the last set bit seen wins.
  logic [31:0] scan_idx;
  always_comb begin
    scan_idx = ALL_ONES;
    for (int i = 0; i < 32; i++) begin
      if (s1[i]) begin
        scan_idx = 32'(i);
      end
    end
  end

  // Any operand naming a special register outside supervisor mode.
  wire logic type_flt = !req_i.supervisor && (req_i.src1_sfr || req_i.src2_sfr || req_i.dst_sfr);

  // ----------------------------------------------------------------------
  // Datapath notes
  // ----------------------------------------------------------------------
  // Every result is worked out at once.
  // The select only picks one of them.
  // This costs area but keeps one cycle.
  //
  // The multiplier is a full 64-bit one.
  // Only its low word is ever stored.
  // The high word serves the overflow test.
  //
  // Signed overflow means the high word
  // is not a copy of bit 31 of the low.
  // The unsigned form never overflows.
  //
  // The divider never sees a zero.
  // A zero divisor is swapped for one.
  // The fault then hides the result.
  //
  // Most negative over minus one would
  // overflow the quotient inside.
  // That case is caught ahead of time.
  // Its remainder is stored as zero.
  //
  // Toggle and rotate use five bits only.
  // Upper bits of the count are ignored.
  //
  // Scan walks up from bit zero.
  // The last set bit seen wins.
  // That is the highest set bit.
  //
  // Byte match only moves the code.
  // The destination is left alone.
  //
  // A privilege fault beats all others.
  // It also blocks the sticky flag.
  //
  // Any fault blocks the result write.
  // Any fault blocks the code write.
  //
  // A masked overflow is no fault.
  // It writes and sets the flag.
  //
  // Unknown selects give a bad-op fault.
  // They write nothing at all.

  // ----------------------------------------------------------------------
  // Operation select
  // ----------------------------------------------------------------------
  ilxu_pkg::ilxu_rsp_s next_rsp;
  always_comb begin
    next_rsp        = '0;
    next_rsp.dst_we = 1'b1;
    next_rsp.fault  = ilxu_pkg::ILXU_FLT_NONE;
    // Operation results.
    unique case (op)
      OP_MUL_U:   next_rsp.result = prod_lo;
      OP_MUL_S: begin
        next_rsp.result = prod_lo;
        if (mul_ovf) begin
          if (req_i.om) next_rsp.of_set = 1'b1;
          else next_rsp.fault = ilxu_pkg::ILXU_FLT_OVERFLOW;
        end
      end
      OP_NAND:    next_rsp.result = ~(s2 & s1);
      OP_NOR:     next_rsp.result = ~(s2 | s1);
      OP_NOT:     next_rsp.result = ~s1;
      OP_NOTAND:  next_rsp.result = ~s2 & s1;
      OP_NOTOR:   next_rsp.result = ~s2 | s1;
      OP_OR:      next_rsp.result = s2 | s1;
      OP_ORNOT:   next_rsp.result = s2 | ~s1;
      OP_TOGGLE:  next_rsp.result = s2 ^ tog_mask;
      OP_REM_U: begin
        next_rsp.result = rem_u;
        if (div_zero) next_rsp.fault = ilxu_pkg::ILXU_FLT_ZERODIV;
      end
      OP_REM_S: begin
        next_rsp.result = rem_s;
        if (div_zero) begin
          next_rsp.fault = ilxu_pkg::ILXU_FLT_ZERODIV;
        end else if (rem_ovf) begin
          if (req_i.om) next_rsp.of_set = 1'b1;
          else next_rsp.fault = ilxu_pkg::ILXU_FLT_OVERFLOW;
        end
      end
      OP_ROTATE:  next_rsp.result = rot_res;
      OP_SCAN: begin
        next_rsp.result = scan_idx;
        next_rsp.cc_we  = 1'b1;
        next_rsp.cc     = (s1 == RST_WORD) ? CC_NONE : CC_FOUND;
      end
      OP_BYTEMAT: begin
        next_rsp.dst_we = 1'b0;
        next_rsp.cc_we  = 1'b1;
        next_rsp.cc     = (|lane_eq) ? CC_FOUND : CC_NONE;
      end
      default: begin
        next_rsp.dst_we = 1'b0;
        next_rsp.fault  = ilxu_pkg::ILXU_FLT_BADOP;
      end
    endcase
    // Privilege check outranks every other outcome and blocks all updates.
    if (type_flt) begin
      next_rsp.fault  = ilxu_pkg::ILXU_FLT_TYPE;
      next_rsp.dst_we = 1'b0;
      next_rsp.cc_we  = 1'b0;
      next_rsp.of_set = 1'b0;
    end
    // An unmasked fault suppresses all architectural writes.
    if (next_rsp.fault != ilxu_pkg::ILXU_FLT_NONE) begin
      next_rsp.dst_we = 1'b0;
      next_rsp.cc_we  = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------------
  // Answer stands one cycle after the request is taken.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      valid_o <= 1'b0;
      rsp_o   <= '0;
    end else if (clk_en_i) begin
      valid_o <= valid_i;
      if (valid_i) rsp_o <= next_rsp;
    end
  end

  // ----------------------------------------------------------------------
  // Event status, mask and interrupt
  // ----------------------------------------------------------------------
  logic [EV_W-1:0] status;    // Sticky event bits.
  logic [EV_W-1:0] irq_mask;  // Interrupt enables.
  logic [31:0]     op_count;  // Number of operations answered.
  wire logic [EV_W-1:0] ev = {3{valid_i}} & {next_rsp.fault == ilxu_pkg::ILXU_FLT_TYPE,
                                            next_rsp.fault == ilxu_pkg::ILXU_FLT_ZERODIV,
                                            next_rsp.fault == ilxu_pkg::ILXU_FLT_OVERFLOW || next_rsp.of_set};
  wire logic wr_status = reg_wr_i && (reg_addr_i == ADDR_STATUS);
  wire logic wr_mask   = reg_wr_i && (reg_addr_i == ADDR_MASK);
  wire logic [EV_W-1:0] clr = wr_status ? reg_wdata_i[EV_W-1:0] : '0;
  // Set wins over clear in the same cycle.
  wire logic [EV_W-1:0] next_status = (status & ~clr) | ev;
  wire logic [31:0] rd_mux = (reg_addr_i == ADDR_STATUS) ? {29'h0, status} :
                             (reg_addr_i == ADDR_MASK)   ? {29'h0, irq_mask} :
                             (reg_addr_i == ADDR_COUNT)  ? op_count : RST_WORD;

  // Status, mask, counter, read data and interrupt output.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      status      <= '0;
      irq_mask    <= '0;
      op_count    <= RST_WORD;
      reg_rdata_o <= RST_WORD;
      irq_o       <= 1'b0;
    end else if (clk_en_i) begin
      status      <= next_status;
      if (wr_mask) irq_mask <= reg_wdata_i[EV_W-1:0];
      if (valid_i) op_count <= op_count + 32'h00000001;
      reg_rdata_o <= reg_rd_i ? rd_mux : RST_WORD;
      irq_o       <= |(next_status & (wr_mask ? reg_wdata_i[EV_W-1:0] : irq_mask));
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);


  // Unsigned product low word.
  AST_MUL_LOW: assert property (clk_en_i && valid_i && (op == OP_MUL_U) && !type_flt |=>
    rsp_o.result == $past(s1 * s2)) else $error("Multiply low word wrong.");

  // Overflow either faults or sets the flag.
  AST_MUL_OVF: assert property (clk_en_i && valid_i && (op == OP_MUL_S) && mul_ovf && !type_flt
    |=> (rsp_o.fault == ilxu_pkg::ILXU_FLT_OVERFLOW) != rsp_o.of_set) else $error("Multiply overflow wrong.");

  // Nand result.
  AST_NAND: assert property (clk_en_i && valid_i && (op == OP_NAND) |=>
    rsp_o.result == ~($past(s1) & $past(s2))) else $error("Nand result wrong.");

  // Nor result.
  AST_NOR: assert property (clk_en_i && valid_i && (op == OP_NOR) |=>
    rsp_o.result == ~($past(s1) | $past(s2))) else $error("Nor result wrong.");

  // Toggle flips exactly one bit.
  AST_TOGGLE: assert property (clk_en_i && valid_i && (op == OP_TOGGLE) |=>
    $countones(rsp_o.result ^ $past(s2)) == 1) else $error("Toggle changed wrong bits.");

  // Zero divisor on the unsigned remainder faults.
  AST_ZERODIV: assert property (clk_en_i && valid_i && (op == OP_REM_U) && div_zero && !type_flt |=>
    rsp_o.fault == ilxu_pkg::ILXU_FLT_ZERODIV && !rsp_o.dst_we) else $error("Zero divide missed.");

  // Scan code follows the result.
  AST_SCAN: assert property (clk_en_i && valid_i && (op == OP_SCAN) && !type_flt |=>
    rsp_o.cc == ((rsp_o.result == ALL_ONES) ? CC_NONE : CC_FOUND)) else $error("Scan code wrong.");

  // Byte match never writes the destination.
  AST_BYTEMAT: assert property (clk_en_i && valid_i && (op == OP_BYTEMAT) |=> !rsp_o.dst_we)
    else $error("Byte match wrote a result.");

  // Privilege fault blocks all writes.
  AST_TYPE: assert property (clk_en_i && valid_i && type_flt |=>
    rsp_o.fault == ilxu_pkg::ILXU_FLT_TYPE && !rsp_o.dst_we && !rsp_o.cc_we) else $error("Type fault missed.");

  // Every request is answered.
  AST_VALID: assert property (clk_en_i && valid_i |=> valid_o) else $error("Answer not given.");

  // Main scenarios.
  COV_MUL_OVF: cover property (clk_en_i && valid_i && (op == OP_MUL_S) && mul_ovf);

  COV_SCAN_ZERO: cover property (clk_en_i && valid_i && (op == OP_SCAN) && (s1 == RST_WORD));

  COV_MATCH: cover property (clk_en_i && valid_i && (op == OP_BYTEMAT) && (|lane_eq));

  COV_IRQ: cover property (irq_o);


endmodule

// >>> verilog/ilxu_pkg.sv
// Package of operation codes, fault codes and constants for the integer logic execution unit.
package ilxu_pkg;

  // ----------------------------------------------------------------------
  // Widths and condition code values
  // ----------------------------------------------------------------------
  localparam int unsigned DATA_W   = 32;          // Operand and result width.
  localparam int unsigned OP_W     = 12;          // Operation select width.
  localparam logic [2:0]  CC_FOUND = 3'h2;        // Condition code 010 binary.
  localparam logic [2:0]  CC_NONE  = 3'h0;        // Condition code 000 binary.
  localparam logic [31:0] ALL_ONES = 32'hffffffff; // Not-found result value.
  localparam logic [31:0] RST_WORD = 32'h00000000; // Reset value of result words.

  // ----------------------------------------------------------------------
  // Operation select codes
  // ----------------------------------------------------------------------
  localparam logic [11:0] OP_MUL_S   = 12'h741; // Signed multiply.
  localparam logic [11:0] OP_MUL_U   = 12'h701; // Unsigned multiply.
  localparam logic [11:0] OP_NAND    = 12'h58e; // Bitwise nand.
  localparam logic [11:0] OP_NOR     = 12'h588; // Bitwise nor.
  localparam logic [11:0] OP_NOT     = 12'h58a; // Bitwise invert.
  localparam logic [11:0] OP_NOTAND  = 12'h584; // Inverted second and first.
  localparam logic [11:0] OP_NOTOR   = 12'h58d; // Inverted second or first.
  localparam logic [11:0] OP_OR      = 12'h587; // Bitwise or.
  localparam logic [11:0] OP_ORNOT   = 12'h58b; // Second or inverted first.
  localparam logic [11:0] OP_TOGGLE  = 12'h580; // Single bit toggle.
  localparam logic [11:0] OP_REM_S   = 12'h748; // Signed remainder.
  localparam logic [11:0] OP_REM_U   = 12'h708; // Unsigned remainder.
  localparam logic [11:0] OP_ROTATE  = 12'h59d; // Rotate left.
  localparam logic [11:0] OP_SCAN    = 12'h641; // Find highest one.
  localparam logic [11:0] OP_BYTEMAT = 12'h5ac; // Byte lane match.

  // ----------------------------------------------------------------------
  // Fault codes
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ILXU_FLT_NONE     = 3'h0,
    ILXU_FLT_OVERFLOW = 3'h1,
    ILXU_FLT_ZERODIV  = 3'h2,
    ILXU_FLT_TYPE     = 3'h3,
    ILXU_FLT_BADOP    = 3'h4
  } ilxu_fault_e;

  // Request from the issue logic.
  typedef struct packed {
    logic [11:0] op;          // Operation select.
    logic [31:0] src1;        // First source operand.
    logic [31:0] src2;        // Second source operand.
    logic        src1_sfr;    // First operand names a special function register.
    logic        src2_sfr;    // Second operand names a special function register.
    logic        dst_sfr;     // Destination names a special function register.
    logic        supervisor;  // Processor is in supervisor mode.
    logic        om;          // Current overflow mask bit.
  } ilxu_req_s;

  // Answer to the issue logic.
  typedef struct packed {
    logic [31:0] result;      // Result word.
    logic        dst_we;      // Destination should be written.
    logic        cc_we;       // Condition code should be updated.
    logic [2:0]  cc;          // New condition code value.
    logic        of_set;      // Set the sticky overflow flag.
    ilxu_fault_e fault;       // Fault raised by this operation.
  } ilxu_rsp_s;

  localparam logic [5:0] RST_SMALL = 6'h00; // Reset value for small flags.

endpackage

// >>> testbench/ilxu_issue_model.sv
// Behavioural model of the instruction issue logic that feeds the execution unit.
module ilxu_issue_model (
  input  wire logic           ref_clk_i, // Core clock.
  output logic                valid_o,   // Request strobe towards the unit.
  output ilxu_pkg::ilxu_req_s req_o      // Request fields towards the unit.
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------------
  // Pending requests
  // ----------------------------------------------------------------------
  ilxu_pkg::ilxu_req_s pend_q[$]; // Requests waiting to be issued, oldest first.

  // Queues one request; it goes out at a later rising edge.
  task automatic send(input ilxu_pkg::ilxu_req_s q);
    pend_q.push_back(q);
  endtask

  // Starts quiet so that nothing is issued before reset is released.
  initial begin
    valid_o = 1'b0;
    req_o   = '0;
  end

  // Issues one request per cycle, back to back while any are pending.
  // Between requests the fields are scrambled so a stale value never passes.
  always @(posedge ref_clk_i) begin
    if (pend_q.size() > 0) begin
      valid_o <= 1'b1;
      req_o   <= pend_q.pop_front();
    end else begin
      valid_o <= 1'b0;
      req_o   <= ~req_o;
    end
  end
endmodule

// >>> testbench/testbench.sv
// Self-checking testbench of the integer logic execution unit.
`define ILXU_CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------------
  logic                ref_clk_i = 1'b0;  // Core clock, 5 ns period.
  logic                rst_n_i   = 1'b0;  // Synchronous reset, active low.
  logic                valid_i;           // Request strobe from the model.
  ilxu_pkg::ilxu_req_s req_i;             // Request fields from the model.
  logic                valid_o;           // Answer strobe.
  ilxu_pkg::ilxu_rsp_s rsp_o;             // Answer fields.
  logic                irq_o;             // Interrupt level.
  logic                clk_en_i  = 1'b1;  // Clock enable.
  logic                reg_wr_i  = 1'b0;  // Register write strobe.
  logic                reg_rd_i  = 1'b0;  // Register read strobe.
  logic [1:0]          reg_addr_i = 2'h0; // Register word index.
  logic [31:0]         reg_wdata_i = 32'h0; // Register write data.
  logic [31:0]         reg_rdata_o;       // Register read data.
  int                  fail_count = 0;    // Mismatches seen.
  int                  num_checks = 0;    // Comparisons made.
  int                  n_sent     = 0;    // Requests issued.
  ilxu_pkg::ilxu_req_s exp_q[$];          // Requests awaiting their answer.
  ilxu_pkg::ilxu_rsp_s exp_rsp;           // Expected answer in hand.
  localparam logic [11:0] LOGIC_OPS [7] = '{ilxu_pkg::OP_NAND, ilxu_pkg::OP_NOR, ilxu_pkg::OP_NOT,
    ilxu_pkg::OP_NOTAND, ilxu_pkg::OP_NOTOR, ilxu_pkg::OP_OR, ilxu_pkg::OP_ORNOT}; // Bitwise family.

  always #2.5 ref_clk_i = ~ref_clk_i; // 200 MHz clock.

  ilxu_issue_model ilxu_issue_model_inst (.ref_clk_i(ref_clk_i), .valid_o(valid_i), .req_o(req_i));
  ilxu_top ilxu_top_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .valid_i(valid_i),
    .req_i(req_i), .valid_o(valid_o), .rsp_o(rsp_o), .irq_o(irq_o), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o));

  // ----------------------------------------------------------------------
  // Reference model of one operation, worked out from the operands alone
  // ----------------------------------------------------------------------
  function automatic ilxu_pkg::ilxu_rsp_s model(input ilxu_pkg::ilxu_req_s q);
    ilxu_pkg::ilxu_rsp_s r;
    longint sp;
    logic ovf;
    logic zd;
    r = '0;
    r.dst_we = 1'b1;
    ovf = 1'b0;
    zd = 1'b0;
    sp = longint'($signed(q.src2)) * longint'($signed(q.src1));
    case (q.op)
      ilxu_pkg::OP_MUL_S, ilxu_pkg::OP_MUL_U: begin
        r.result = q.src2 * q.src1;
        ovf = (q.op == ilxu_pkg::OP_MUL_S) && (sp != longint'($signed(r.result)));
      end
      ilxu_pkg::OP_NAND:   r.result = ~(q.src2 & q.src1);
      ilxu_pkg::OP_NOR:    r.result = ~(q.src2 | q.src1);
      ilxu_pkg::OP_NOT:    r.result = ~q.src1;
      ilxu_pkg::OP_NOTAND: r.result = ~q.src2 & q.src1;
      ilxu_pkg::OP_NOTOR:  r.result = ~q.src2 | q.src1;
      ilxu_pkg::OP_OR:     r.result = q.src2 | q.src1;
      ilxu_pkg::OP_ORNOT:  r.result = q.src2 | ~q.src1;
      ilxu_pkg::OP_TOGGLE: r.result = q.src2 ^ (32'h1 << q.src1[4:0]);
      ilxu_pkg::OP_ROTATE: r.result = (q.src2 << q.src1[4:0]) | (q.src2 >> (32 - q.src1[4:0]));
      ilxu_pkg::OP_REM_S: begin
        zd = (q.src1 == 32'h0);
        ovf = (q.src2 == 32'h80000000) && (q.src1 == 32'hffffffff);
        if (!zd && !ovf) begin
          r.result = $signed(q.src2) % $signed(q.src1);
        end
      end
      ilxu_pkg::OP_REM_U: begin
        zd = (q.src1 == 32'h0);
        r.result = zd ? 32'h0 : q.src2 % q.src1;
      end
      ilxu_pkg::OP_SCAN: begin
        r.cc_we = 1'b1;
        r.result = ilxu_pkg::ALL_ONES;
        for (int i = 0; i < 32; i++) begin
          if (q.src1[i]) begin
            r.result = 32'(i);
            r.cc = ilxu_pkg::CC_FOUND;
          end
        end
      end
      ilxu_pkg::OP_BYTEMAT: begin
        r.dst_we = 1'b0;
        r.cc_we = 1'b1;
        for (int i = 0; i < 4; i++) begin
          if (q.src1[8*i +: 8] == q.src2[8*i +: 8]) begin
            r.cc = ilxu_pkg::CC_FOUND;
          end
        end
      end
      default: r.fault = ilxu_pkg::ILXU_FLT_BADOP;
    endcase
    if (ovf && q.om) begin
      r.of_set = 1'b1;
    end else if (ovf) begin
      r.fault = ilxu_pkg::ILXU_FLT_OVERFLOW;
    end
    if (zd) begin
      r.fault = ilxu_pkg::ILXU_FLT_ZERODIV;
    end
    if ((q.src1_sfr || q.src2_sfr || q.dst_sfr) && !q.supervisor) begin
      r.fault = ilxu_pkg::ILXU_FLT_TYPE;
    end
    if (r.fault != ilxu_pkg::ILXU_FLT_NONE) begin
      r.dst_we = 1'b0;
      r.cc_we = 1'b0;
      r.of_set = 1'b0;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  // Queues one request; ctl is {src1_sfr, src2_sfr, dst_sfr, supervisor, om}.
  task automatic push(input logic [11:0] op, input logic [31:0] s1, input logic [31:0] s2,
                      input logic [4:0] ctl);
    ilxu_pkg::ilxu_req_s q;
    q = {op, s1, s2, ctl};
    exp_q.push_back(q);
    ilxu_issue_model_inst.send(q);
    n_sent++;
  endtask

  // One write cycle on the register port.
  task automatic reg_write(input logic [1:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // One read cycle; the data is looked at in the cycle after the strobe.
  task automatic reg_check(input logic [1:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    `ILXU_CHK(reg_rdata_o, e)
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Compares every answer with the model, in issue order.
  always @(posedge ref_clk_i) begin
    if (rst_n_i && valid_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        `ILXU_CHK(valid_o, 1'b0)
      end else begin
        exp_rsp = model(exp_q.pop_front());
        `ILXU_CHK({rsp_o.dst_we, rsp_o.cc_we, rsp_o.of_set, rsp_o.fault}, {exp_rsp.dst_we, exp_rsp.cc_we, exp_rsp.of_set, exp_rsp.fault})
        if (exp_rsp.dst_we) `ILXU_CHK(rsp_o.result, exp_rsp.result)
        if (exp_rsp.cc_we) `ILXU_CHK(rsp_o.cc, exp_rsp.cc)
      end
    end
  end

  // Cuts a hang short.
  initial begin
    #50000;
    fail_count++;
    finish_test();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    reg_write(2'h2, 32'hffffffff);
    reg_write(2'h3, 32'hffffffff);
    for (int a = 0; a < 4; a++) reg_check(2'(a), 32'h0);
    $display("TEST registers done");
    foreach (LOGIC_OPS[i]) push(LOGIC_OPS[i], 32'hf0f0ff00, 32'hff00f0f0, 5'h02);
    push(ilxu_pkg::OP_MUL_S, 32'h3, 32'hfffffffb, 5'h02);
    push(ilxu_pkg::OP_MUL_U, 32'h3, 32'hfffffffb, 5'h02);
    push(ilxu_pkg::OP_MUL_S, 32'h00010000, 32'h00010000, 5'h02);
    push(ilxu_pkg::OP_MUL_S, 32'h00010000, 32'h00010000, 5'h03);
    push(ilxu_pkg::OP_MUL_U, 32'h00010000, 32'h00010000, 5'h02);
    push(ilxu_pkg::OP_TOGGLE, 32'h25, 32'h12345678, 5'h02);
    push(ilxu_pkg::OP_TOGGLE, 32'h1f, 32'h0, 5'h02);
    push(ilxu_pkg::OP_ROTATE, 32'hd, 32'h80000001, 5'h02);
    push(ilxu_pkg::OP_ROTATE, 32'h0, 32'ha5a5a5a5, 5'h02);
    push(ilxu_pkg::OP_REM_S, 32'h7, 32'hfffffff6, 5'h02);
    push(ilxu_pkg::OP_REM_S, 32'hfffffff9, 32'ha, 5'h02);
    push(ilxu_pkg::OP_REM_U, 32'h7, 32'hfffffff6, 5'h02);
    push(ilxu_pkg::OP_REM_S, 32'h0, 32'h5, 5'h02);
    push(ilxu_pkg::OP_REM_U, 32'h0, 32'h5, 5'h02);
    push(ilxu_pkg::OP_REM_S, 32'hffffffff, 32'h80000000, 5'h02);
    push(ilxu_pkg::OP_REM_S, 32'hffffffff, 32'h80000000, 5'h03);
    push(ilxu_pkg::OP_SCAN, 32'h00012345, 32'h0, 5'h02);
    push(ilxu_pkg::OP_SCAN, 32'h80000000, 32'h0, 5'h02);
    push(ilxu_pkg::OP_SCAN, 32'h0, 32'h0, 5'h02);
    push(ilxu_pkg::OP_BYTEMAT, 32'h00ab0011, 32'h11ab1100, 5'h02);
    push(ilxu_pkg::OP_BYTEMAT, 32'h01020304, 32'h05060708, 5'h02);
    push(12'h000, 32'h1, 32'h2, 5'h02);
    push(ilxu_pkg::OP_OR, 32'h1, 32'h2, 5'h10);
    push(ilxu_pkg::OP_NOT, 32'h1, 32'h2, 5'h04);
    push(ilxu_pkg::OP_OR, 32'h1, 32'h2, 5'h12);
    push(ilxu_pkg::OP_MUL_S, 32'h00010000, 32'h00010000, 5'h09);
    for (int i = 0; i < 200 && exp_q.size() > 0; i++) @(posedge ref_clk_i);
    `ILXU_CHK(exp_q.size(), 0)
    $display("TEST operations done");
    reg_check(2'h2, 32'(n_sent));
    reg_check(2'h0, 32'h7);
    `ILXU_CHK(irq_o, 1'b0)
    reg_write(2'h1, 32'h2);
    repeat (2) @(posedge ref_clk_i);
    #1;
    `ILXU_CHK(irq_o, 1'b1)
    @(posedge ref_clk_i);
    clk_en_i <= 1'b0;
    reg_write(2'h1, 32'h0);
    clk_en_i <= 1'b1;
    `ILXU_CHK(irq_o, 1'b1)
    reg_write(2'h0, 32'h2);
    repeat (2) @(posedge ref_clk_i);
    #1;
    `ILXU_CHK(irq_o, 1'b0)
    reg_check(2'h0, 32'h5);
    reg_check(2'h1, 32'h2);
    $display("TEST interrupt done");
    finish_test();
  end
endmodule
